// [hw/alu_slice_map.vh]
// operation codes, flag positions and reset values for the alu slice
`ifndef ALU_SLICE_MAP_VH
`define ALU_SLICE_MAP_VH
// operation select codes
`define OP_NOP        4'h0
`define OP_SUB_REG    4'h1
`define OP_SUB_MEM    4'h2
`define OP_SUB_IMM    4'h3
`define OP_SWAP_MEM   4'h4
`define OP_SWAP_REG   4'h5
`define OP_SKIP_ZERO  4'h6
`define OP_COPY_SKIP  4'h7
`define OP_BIT_SKIP   4'h8
`define OP_TABLE_READ 4'h9
`define OP_TABLE_LAST 4'hA
`define OP_XOR_REG    4'hB
`define OP_XOR_MEM    4'hC
`define OP_XOR_IMM    4'hD
// flag bit positions in the status byte
`define FLAG_CARRY    0
`define FLAG_HALF     1
`define FLAG_ZERO     2
`define FLAG_OVERFLOW 3
// reset values
`define WORK_RESET    8'h00
`define FLAGS_RESET   4'h0
`define LATCH_RESET   8'h00
`endif

// [hw/alu_slice.v]
// execution slice: subtract, nibble swap, zero skips, table reads, exclusive-or
// Function
// RQ1: subtract clears carry on negative difference, sets it on zero or positive.
// RQ2: subtract-to-memory writes working register minus operand to memory, sets four flags.
// RQ3: subtract-immediate puts working register minus constant in working register.
// RQ4: nibble swap exchanges memory nibbles in place, flags unchanged.
// RQ5: swap-to-register puts swapped byte in working register, memory and flags untouched.
// RQ6: byte skip-if-zero skips next instruction when memory byte is zero.
// RQ7: a taken skip adds one dummy cycle, two instruction cycles total.
// RQ8: copy-and-skip loads byte to working register, skips if zero.
// RQ9: bit skip skips next instruction when selected bit is zero.
// RQ10: table read fetches word at high and low pointer; low to memory, high to latch.
// RQ11: last-page table read uses last page and low pointer only.
// RQ12: register exclusive-or into working register, zero flag only.
// RQ13: exclusive-or-to-memory writes result to memory, zero flag only.
// RQ14: immediate exclusive-or into working register, zero flag only.
// RQ15: register subtract keeps difference in working register, sets four flags.
// RQ16: other operations take one cycle, table reads two; unnamed flags hold their values.
`include "alu_slice_map.vh"
`default_nettype none
module alu_slice #(
  parameter PROG_ADDR_W = 10, // program memory address width
  parameter HAS_HIGH_PTR = 1  // 1 when a high table pointer exists
) (
  // clock and reset
  input  wire                   mclk,
  input  wire                   reset,
  // instruction issue
  input  wire                   op_valid,
  input  wire [3:0]             op_code,
  input  wire [7:0]             immediate,
  input  wire [2:0]             bit_select,
  input  wire [7:0]             mem_operand,
  input  wire [7:0]             table_pointer_low,
  input  wire [7:0]             table_pointer_high,
  // program memory read port, word valid in the same cycle as the address
  input  wire [13:0]            prog_word,
  output reg  [PROG_ADDR_W-1:0] prog_addr,
  output reg                    prog_rd,
  // results
  output reg  [7:0]             working_register,
  output reg  [7:0]             mem_wdata,
  output reg                    mem_we,
  output reg  [7:0]             table_high_byte_latch,
  output reg                    overflow_flag,
  output reg                    zero_flag,
  output reg                    half_carry_flag,
  output reg                    carry_flag,
  output reg                    skip_next,
  output reg                    busy
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_DUMMY = 3'b010;
  localparam ST_TABLE = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;

  // difference with flags packed as {overflow, half carry, carry, difference}
  function [10:0] subtract;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] full;
    reg   [4:0] low;
    begin
      full = {1'b0, a} - {1'b0, b};
      low  = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      subtract = {(a[7] ^ b[7]) & (a[7] ^ full[7]), ~low[4], ~full[8], full[7:0]};
    end
  endfunction

  // nibble exchange
  function [7:0] swap_nibbles;
    input [7:0] v;
    begin
      swap_nibbles = {v[3:0], v[7:4]};
    end
  endfunction

  reg [10:0] sub_res;
  reg [7:0]  xor_res;
  wire       accept = op_valid & (state_reg == ST_IDLE);

  // operand selection for subtract and exclusive-or
  always @* begin
    if (op_code == `OP_SUB_IMM) begin
      sub_res = subtract(working_register, immediate);
    end else begin
      sub_res = subtract(working_register, mem_operand);
    end
    if (op_code == `OP_XOR_IMM) begin
      xor_res = working_register ^ immediate;
    end else begin
      xor_res = working_register ^ mem_operand;
    end
  end

  // skip decision for the three skip forms
  reg take_skip;
  always @* begin
    case (op_code)
      `OP_SKIP_ZERO: take_skip = (mem_operand == 8'h00);      // see RQ6
      `OP_COPY_SKIP: take_skip = (mem_operand == 8'h00);      // see RQ8
      `OP_BIT_SKIP:  take_skip = ~mem_operand[bit_select];    // see RQ9
      default:       take_skip = 1'b0;
    endcase
  end

  // sequencing: dummy cycle after a taken skip, wait for table word
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept && take_skip) begin
          state_next = ST_DUMMY;                              // see RQ7
        end else if (accept && (op_code == `OP_TABLE_READ || op_code == `OP_TABLE_LAST)) begin
          state_next = ST_TABLE;
        end
      end
      ST_DUMMY: state_next = ST_IDLE;
      ST_TABLE: state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // table word address: current pointers or last page
  reg [PROG_ADDR_W-1:0] table_addr;
  always @* begin
    if (op_code == `OP_TABLE_LAST) begin
      table_addr = {{(PROG_ADDR_W-8){1'b1}}, table_pointer_low};          // see RQ11
    end else if (HAS_HIGH_PTR != 0) begin
      table_addr = {table_pointer_high[PROG_ADDR_W-9:0], table_pointer_low}; // see RQ10
    end else begin
      table_addr = {{(PROG_ADDR_W-8){1'b0}}, table_pointer_low};         // see RQ10
    end
  end

  // state and datapath registers
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg             <= ST_IDLE;
      working_register      <= `WORK_RESET;
      mem_wdata             <= 8'h00;
      mem_we                <= 1'b0;
      table_high_byte_latch <= `LATCH_RESET;
      overflow_flag         <= 1'b0;
      zero_flag             <= 1'b0;
      half_carry_flag       <= 1'b0;
      carry_flag            <= 1'b0;
      skip_next             <= 1'b0;
      busy                  <= 1'b0;
      prog_addr             <= {PROG_ADDR_W{1'b0}};
      prog_rd               <= 1'b0;
    end else begin
      state_reg <= state_next;
      mem_we    <= 1'b0;                                       // see RQ16
      prog_rd   <= 1'b0;
      skip_next <= 1'b0;
      busy      <= (state_next != ST_IDLE);
      if (state_reg == ST_TABLE) begin
        mem_wdata             <= prog_word[7:0];               // see RQ10
        mem_we                <= 1'b1;
        table_high_byte_latch <= {2'b00, prog_word[13:8]};     // see RQ10
      end else if (accept) begin
        case (op_code)
          `OP_SUB_REG, `OP_SUB_IMM, `OP_SUB_MEM: begin
            if (op_code == `OP_SUB_MEM) begin
              mem_wdata <= sub_res[7:0];                       // see RQ2
              mem_we    <= 1'b1;
            end else begin
              working_register <= sub_res[7:0];                // see RQ3 see RQ15
            end
            carry_flag      <= sub_res[8];                     // see RQ1
            half_carry_flag <= sub_res[9];
            overflow_flag   <= sub_res[10];
            zero_flag       <= (sub_res[7:0] == 8'h00);
          end
          `OP_SWAP_MEM: begin
            mem_wdata <= swap_nibbles(mem_operand);            // see RQ4
            mem_we    <= 1'b1;
          end
          `OP_SWAP_REG: working_register <= swap_nibbles(mem_operand); // see RQ5
          `OP_SKIP_ZERO, `OP_BIT_SKIP: skip_next <= take_skip; // see RQ6 see RQ9
          `OP_COPY_SKIP: begin
            working_register <= mem_operand;                   // see RQ8
            skip_next        <= take_skip;
          end
          `OP_TABLE_READ, `OP_TABLE_LAST: begin
            prog_addr <= table_addr;
            prog_rd   <= 1'b1;
          end
          `OP_XOR_REG, `OP_XOR_IMM: begin
            working_register <= xor_res;                       // see RQ12 see RQ14
            zero_flag        <= (xor_res == 8'h00);
          end
          `OP_XOR_MEM: begin
            mem_wdata <= xor_res;                              // see RQ13
            mem_we    <= 1'b1;
            zero_flag <= (xor_res == 8'h00);
          end
          default: mem_we <= 1'b0;
        endcase
      end
    end
  end

endmodule // alu_slice
`default_nettype wire

// [test/alu_slice_chk.sv]
// timing and result assertions for the alu slice
`default_nettype none
`include "alu_slice_map.vh"
module alu_slice_chk #(
  parameter PROG_ADDR_W  = 10,
  parameter HAS_HIGH_PTR = 1
) (
  // control and handshake
  input wire logic mclk, reset, op_valid, prog_rd, mem_we, skip_next, busy,
  input wire logic overflow_flag, zero_flag, half_carry_flag, carry_flag,
  // operands and results
  input wire logic [3:0] op_code,
  input wire logic [2:0] bit_select,
  input wire logic [7:0] immediate, mem_operand, table_pointer_low,
  input wire logic [13:0] prog_word,
  input wire logic [PROG_ADDR_W-1:0] prog_addr,
  input wire logic [7:0] working_register, mem_wdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // accepted issue and packed flags
  wire go = op_valid && !busy;
  wire [3:0] fl = {overflow_flag, zero_flag, half_carry_flag, carry_flag};
  // taken skip: one dummy cycle, then free
  sequence s_dummy;
    skip_next && busy ##1 !busy;
  endsequence
  // table fetch: read strobe, word returns, low byte written
  sequence s_fetch;
    prog_rd ##1 mem_we && mem_wdata == $past(prog_word[7:0]);
  endsequence
  a_sub_carry: assert property (go && op_code == `OP_SUB_REG |=>
    carry_flag == ($past(working_register) >= $past(mem_operand))) else $error("bad carry");
  a_sub_mem: assert property (go && op_code == `OP_SUB_MEM |=> mem_we &&
    mem_wdata == 8'($past(working_register) - $past(mem_operand))) else $error("bad diff");
  a_swap_mem: assert property (go && op_code == `OP_SWAP_MEM |=> mem_we &&
    {mem_wdata[3:0], mem_wdata[7:4]} == $past(mem_operand) && $stable(fl)) else $error("swap");
  a_zero_skip: assert property (go && op_code == `OP_SKIP_ZERO && mem_operand == 8'h00
    |=> s_dummy) else $error("no skip on zero");
  a_copy_skip: assert property (go && op_code == `OP_COPY_SKIP |=>
    working_register == $past(mem_operand) && $stable(fl)) else $error("copy");
  a_bit_skip: assert property (go && op_code == `OP_BIT_SKIP && !mem_operand[bit_select]
    |=> s_dummy) else $error("no bit skip");
  a_last_page: assert property (go && op_code == `OP_TABLE_LAST |=>
    prog_addr == {{(PROG_ADDR_W-8){1'b1}}, $past(table_pointer_low)} ##0 s_fetch)
    else $error("last page read");
  a_xor_imm: assert property (go && op_code == `OP_XOR_IMM |=> carry_flag == $past(carry_flag)
    && working_register == ($past(working_register) ^ $past(immediate))) else $error("xor");
endmodule // alu_slice_chk
bind alu_slice alu_slice_chk #(.PROG_ADDR_W(PROG_ADDR_W), .HAS_HIGH_PTR(HAS_HIGH_PTR))
  alu_slice_chk_i (.*);
`default_nettype wire

// [test/alu_slice_bench.sv]
// self-checking bench for the alu slice
`default_nettype none
`include "alu_slice_map.vh"
module alu_slice_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, reset = 1, op_valid = 0, mem_we, skip_next, busy, prog_rd, vf, z, h, c;
  logic [3:0]  op_code = 4'h0, fl = 4'h0;
  logic [2:0]  bit_select = 3'h0;
  logic [7:0]  immediate = 8'h00, mem_operand = 8'h00, tpl = 8'h00, tph = 8'h00, wr, wd, th;
  logic [7:0]  w = 8'h00;
  logic [13:0] prog_word = 14'h0000;
  logic [9:0]  prog_addr;
  integer      seed = 32'h9f87_65c1, miscompares = 0, total_checks = 0, cyc = 0, k;
  alu_slice alu_slice_i (.mclk(mclk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .immediate(immediate), .bit_select(bit_select), .mem_operand(mem_operand),
    .table_pointer_low(tpl), .table_pointer_high(tph), .prog_word(prog_word),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .working_register(wr), .mem_wdata(wd),
    .mem_we(mem_we), .table_high_byte_latch(th), .overflow_flag(vf), .zero_flag(z),
    .half_carry_flag(h), .carry_flag(c), .skip_next(skip_next), .busy(busy));
  // clock
  initial forever #2 mclk = ~mclk;
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // counts and verdict
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      stop_test;
    end
  end
  // issue one op, model it, compare
  task automatic run(input logic [3:0] op, input logic [7:0] m, x, input logic [2:0] s);
    logic [7:0]  b, r;
    logic [8:0]  d;
    logic [13:0] pw;
    logic        sk;
    b = (op == `OP_SUB_IMM || op == `OP_XOR_IMM) ? x : m;
    d = {1'b0, w} - {1'b0, b};
    r = w ^ b;
    sk = 0;
    pw = $random(seed);
    @(posedge mclk);
    op_valid <= 1;
    {op_code, immediate, mem_operand, bit_select} <= {op, x, m, s};
    {tpl, tph} <= 16'($random(seed));
    prog_word <= pw;
    @(posedge mclk) op_valid <= 0;
    @(negedge mclk);
    case (op)
      `OP_SUB_REG, `OP_SUB_MEM, `OP_SUB_IMM: begin
        r = d[7:0];
        fl = {(w[7] != b[7]) && (r[7] != w[7]), r == 8'h00, w[3:0] >= b[3:0], !d[8]};
        if (op == `OP_SUB_MEM) chk(wd, r);
        else w = r;
      end
      `OP_SWAP_MEM: chk(wd, {m[3:0], m[7:4]});
      `OP_SWAP_REG: w = {m[3:0], m[7:4]};
      `OP_SKIP_ZERO: sk = m == 8'h00;
      `OP_COPY_SKIP: {w, sk} = {m, m == 8'h00};
      `OP_BIT_SKIP: sk = !m[s];
      `OP_XOR_REG, `OP_XOR_IMM: {w, fl[2]} = {r, r == 8'h00};
      `OP_XOR_MEM: begin
        chk(wd, r);
        fl[2] = r == 8'h00;
      end
      `OP_TABLE_READ, `OP_TABLE_LAST: begin
        chk({prog_rd, prog_addr}, {1'b1, (op == `OP_TABLE_LAST) ? 2'b11 : tph[1:0], tpl});
        @(posedge mclk) prog_word <= ~pw;
        @(negedge mclk) chk({mem_we, wd, th}, {1'b1, pw[7:0], 2'b00, pw[13:8]});
      end
      default: ;
    endcase
    if (op != `OP_TABLE_READ && op != `OP_TABLE_LAST)
      chk({mem_we, busy}, {op == `OP_SUB_MEM || op == `OP_SWAP_MEM || op == `OP_XOR_MEM, sk});
    chk({wr, vf, z, h, c, skip_next}, {w, fl, sk});
    repeat (4) if (busy) @(negedge mclk);
    chk(busy, 0);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 0;
    run(`OP_COPY_SKIP, 8'h80, 8'h00, 3'h0);
    run(`OP_SUB_REG, 8'h01, 8'h00, 3'h0);
    run(`OP_SUB_IMM, 8'h00, 8'h7f, 3'h0);
    run(`OP_SUB_MEM, 8'h01, 8'h00, 3'h0);
    run(`OP_BIT_SKIP, 8'hfe, 8'h00, 3'h0);
    for (k = 0; k < 14; k++) run(k[3:0], 8'h00, 8'h5a, 3'h7);
    $display("corner cases done");
    for (k = 0; k < 400; k++)
      run($unsigned($random(seed)) % 14, ($random(seed) & 3) ? $random(seed) : 0,
          $random(seed), $random(seed));
    $display("random mix done");
    stop_test;
  end
endmodule // alu_slice_bench
`default_nettype wire
